/* src/fsp_pkg.sv */
package fsp_pkg;

  // clock and flash bus timing
  localparam int CLK_MHZ     = 40;
  localparam int T_PULSE_NS  = 80;
  localparam int T_REC_NS    = 30;
  localparam int T_PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_REC_CYC   = (T_REC_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PULSE_LAST = 4'(T_PULSE_CYC - 1);
  localparam logic [3:0] REC_LAST   = 4'(T_REC_CYC - 1);

  // flash command codes
  localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [15:0] CMD_PAGE_BUF    = 16'h00E8;
  localparam logic [15:0] CMD_READ_ID     = 16'h0090;
  // word offset of the partition configuration code in id space
  localparam logic [20:0] PCR_ID_OFFSET   = 21'h000006;
  localparam logic [3:0]  RETRY_MAX       = 4'h8;

  // wishbone register byte offsets
  localparam logic [4:0] ADR_CTRL  = 5'h00;
  localparam logic [4:0] ADR_ADDR  = 5'h04;
  localparam logic [4:0] ADR_WDATA = 5'h08;
  localparam logic [4:0] ADR_RDATA = 5'h0C;
  localparam logic [4:0] ADR_STAT  = 5'h10;

  // reset values of software registers
  localparam logic [20:0] ADDR_RST  = 21'h000000;
  localparam logic [15:0] WDATA_RST = 16'h0000;

  // flash register bit positions and valid masks
  localparam int SR_READY     = 7;
  localparam int SR_ERASE_SUS = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR  = 4;
  localparam int SR_SUPPLY    = 3;
  localparam int SR_PROG_SUS  = 2;
  localparam int SR_PROTECT   = 1;
  localparam int XSR_PB_AVAIL = 7;
  localparam int PCR_LSB      = 8;
  localparam logic [15:0] SR_MASK      = 16'h00FE;
  localparam logic [15:0] SR_BUSY_MASK = 16'h0080;
  localparam logic [15:0] XSR_MASK     = 16'h0080;
  localparam logic [15:0] PCR_MASK     = 16'h0700;

  // status word bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_READY   = 1;
  localparam int ST_SEQERR  = 2;
  localparam int ST_PBAVAIL = 3;
  localparam int ST_PBFAIL  = 4;
  localparam int ST_RB      = 5;
  localparam int ST_PCNT    = 8;
  localparam int ST_CONC    = 10;

  typedef enum logic [2:0] {
    OP_STATUS  = 3'h0,
    OP_XSTATUS = 3'h1,
    OP_PCR     = 3'h2,
    OP_READ    = 3'h3,
    OP_WRITE   = 3'h4
  } fsp_op_e;

  typedef struct packed {
    logic        write;
    logic [20:0] addr;
    logic [15:0] data;
  } fsp_req_s;

endpackage : fsp_pkg

/* src/fsp_bus.sv */
`timescale 1ns/1ps
`default_nettype none
module fsp_bus (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             req_valid_i,
  input  wire fsp_pkg::fsp_req_s req_i,
  output logic                  req_ready_o,
  output logic                  done_o,
  output logic [15:0]           rdata_o,
  output logic [20:0]           flash_addr_o,
  output logic                  ce_n_o,
  output logic                  oe_n_o,
  output logic                  we_n_o,
  output logic [15:0]           dq_o,
  output logic                  dq_oe_o,
  input  wire logic [15:0]      dq_i
);
  import fsp_pkg::*;

  typedef enum logic [1:0] {
    B_IDLE  = 2'b00,
    B_SETUP = 2'b01,
    B_PULSE = 2'b11,
    B_HOLD  = 2'b10
  } fsp_bst_e;

  fsp_bst_e    st_ff, nxt_st;
  logic [3:0]  cnt_ff, nxt_cnt;
  fsp_req_s    lat_ff, nxt_lat;
  logic [15:0] rd_ff, nxt_rd;
  logic        done_ff, nxt_done;

  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_lat  = lat_ff;
    nxt_rd   = rd_ff;
    nxt_done = 1'b0;
    case (st_ff)
      B_IDLE: begin
        if (req_valid_i) begin
          nxt_lat = req_i;
          nxt_st  = B_SETUP;
        end
      end
      B_SETUP: begin
        nxt_cnt = PULSE_LAST;
        nxt_st  = B_PULSE;
      end
      B_PULSE: begin
        if (cnt_ff == 4'h0) begin
          // sample at the end of the strobe, after the access time
          if (!lat_ff.write) begin
            nxt_rd = dq_i;
          end
          nxt_cnt = REC_LAST;
          nxt_st  = B_HOLD;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      B_HOLD: begin
        if (cnt_ff == 4'h0) begin
          nxt_done = 1'b1;
          nxt_st   = B_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: nxt_st = B_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff   <= B_IDLE;
      cnt_ff  <= 4'h0;
      lat_ff  <= '0;
      rd_ff   <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      lat_ff  <= nxt_lat;
      rd_ff   <= nxt_rd;
      done_ff <= nxt_done;
    end
  end

  assign req_ready_o  = (st_ff == B_IDLE);
  assign done_o       = done_ff;
  assign rdata_o      = rd_ff;
  assign flash_addr_o = lat_ff.addr;
  assign ce_n_o       = (st_ff == B_IDLE);
  assign we_n_o       = !((st_ff == B_PULSE) && lat_ff.write);
  assign oe_n_o       = !((st_ff == B_PULSE) && !lat_ff.write);
  assign dq_o         = lat_ff.data;
  // drive data only through a write cycle, never during idle or reads
  assign dq_oe_o      = (st_ff != B_IDLE) && lat_ff.write;

  strobe_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(we_n_o) |-> !we_n_o [*4] ##1 we_n_o)
    else $error("write strobe length wrong");

  no_contend_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !oe_n_o |-> !dq_oe_o && we_n_o)
    else $error("bus driven while output enabled");

endmodule : fsp_bus
`default_nettype wire

/* src/fsp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - ready concerns partition, not shared engine
// - bits 6..1 invalid while busy
// - mask status bits 15..8 and 0
// - reissue page buffer setup when unavailable
// - mask extended bits 15..8, 6..0
// - mask configuration bits 15..11, 7..0
module fsp_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic [20:0]      flash_addr_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [15:0]      dq_o,
  output logic             dq_oe_o,
  input  wire logic [15:0] dq_i,
  input  wire logic        ready_busy_n_i
);
  import fsp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD  = 3'b001,
    S_CMDW = 3'b011,
    S_RD   = 3'b010,
    S_RDW  = 3'b110,
    S_EVAL = 3'b111
  } fsp_st_e;

  fsp_st_e     st_ff, nxt_st;
  fsp_op_e     op_ff, nxt_op;
  logic [20:0] addr_ff, nxt_addr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] res_ff, nxt_res;
  fsp_op_e     kind_ff, nxt_kind;
  logic [3:0]  retry_ff, nxt_retry;
  logic        pbfail_ff, nxt_pbfail;
  logic        ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;

  fsp_req_s    req;
  logic        req_valid;
  logic        req_ready;
  logic        bus_done;
  logic [15:0] bus_rdata;
  logic        wr_commit;
  logic [31:0] stat;
  logic [2:0]  layout;

  fsp_bus u_bus (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .req_valid_i  (req_valid),
    .req_i        (req),
    .req_ready_o  (req_ready),
    .done_o       (bus_done),
    .rdata_o      (bus_rdata),
    .flash_addr_o (flash_addr_o),
    .ce_n_o       (ce_n_o),
    .oe_n_o       (oe_n_o),
    .we_n_o       (we_n_o),
    .dq_o         (dq_o),
    .dq_oe_o      (dq_oe_o),
    .dq_i         (dq_i)
  );

  // a write takes effect on the edge that ends the ack cycle
  assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;

  // request to the flash bus engine
  always_comb begin
    req.write = (st_ff == S_CMD);
    req.addr  = addr_ff;
    req.data  = wdata_ff;
    if (st_ff == S_CMD) begin
      case (op_ff)
        OP_STATUS:  req.data = CMD_READ_STATUS;
        OP_XSTATUS: req.data = CMD_PAGE_BUF;
        OP_PCR:     req.data = CMD_READ_ID;
        default:    req.data = wdata_ff;
      endcase
    end else if (op_ff == OP_PCR) begin
      req.addr = addr_ff | PCR_ID_OFFSET;
    end
  end
  assign req_valid = (st_ff == S_CMD) || (st_ff == S_RD);

  always_comb begin
    nxt_st     = st_ff;
    nxt_op     = op_ff;
    nxt_addr   = addr_ff;
    nxt_wdata  = wdata_ff;
    nxt_res    = res_ff;
    nxt_kind   = kind_ff;
    nxt_retry  = retry_ff;
    nxt_pbfail = pbfail_ff;
    case (st_ff)
      S_IDLE: begin
        // registers stay frozen while an operation runs
        if (wr_commit && wb_sel_i[0]) begin
          if (wb_adr_i == ADR_ADDR) begin
            nxt_addr = wb_dat_i[20:0];
          end
          if (wb_adr_i == ADR_WDATA) begin
            nxt_wdata = wb_dat_i[15:0];
          end
          if (wb_adr_i == ADR_CTRL && wb_dat_i[2:0] <= OP_WRITE) begin
            nxt_op     = fsp_op_e'(wb_dat_i[2:0]);
            nxt_retry  = 4'h0;
            nxt_pbfail = 1'b0;
            nxt_st     = (wb_dat_i[2:0] == OP_READ) ? S_RD : S_CMD;
          end
        end
      end
      S_CMD: if (req_ready) nxt_st = S_CMDW;
      S_CMDW: begin
        if (bus_done) begin
          nxt_st = (op_ff == OP_WRITE) ? S_IDLE : S_RD;
        end
      end
      S_RD: if (req_ready) nxt_st = S_RDW;
      S_RDW: if (bus_done) nxt_st = S_EVAL;
      S_EVAL: begin
        nxt_kind = op_ff;
        nxt_st   = S_IDLE;
        case (op_ff)
          OP_STATUS: begin
            // flags below ready mean nothing while busy
            nxt_res = bus_rdata[SR_READY] ? (bus_rdata & SR_MASK)
                                          : (bus_rdata & SR_BUSY_MASK);
          end
          OP_XSTATUS: begin
            nxt_res = bus_rdata & XSR_MASK;
            if (!bus_rdata[XSR_PB_AVAIL]) begin
              if (retry_ff != RETRY_MAX) begin
                nxt_retry = retry_ff + 4'h1;
                nxt_st    = S_CMD;
              end else begin
                nxt_pbfail = 1'b1;
              end
            end
          end
          OP_PCR: nxt_res = bus_rdata & PCR_MASK;
          default: nxt_res = bus_rdata;
        endcase
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  assign layout = res_ff[PCR_LSB +: 3];

  // live busy and ready/busy pin, plus a decoded view of the most recent register read
  always_comb begin
    stat = 32'h0000_0000;
    stat[ST_BUSY] = (st_ff != S_IDLE);
    stat[ST_RB]   = ready_busy_n_i;
    if (kind_ff == OP_STATUS) begin
      // ready only speaks for the addressed partition
      stat[ST_READY]  = res_ff[SR_READY];
      stat[ST_SEQERR] = res_ff[SR_ERASE_ERR] && res_ff[SR_PROG_ERR];
    end
    if (kind_ff == OP_XSTATUS) begin
      stat[ST_PBAVAIL] = res_ff[XSR_PB_AVAIL];
    end
    stat[ST_PBFAIL] = pbfail_ff;
    if (kind_ff == OP_PCR) begin
      // partitions minus one equals the number of set layout bits
      stat[ST_PCNT +: 2] = 2'({1'b0, layout[0]} + {1'b0, layout[1]}
                              + {1'b0, layout[2]});
      stat[ST_CONC] = (layout != 3'b000);
    end
  end

  // wishbone slave: registered ack, one cycle after the request
  always_comb begin
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_dat = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CTRL:  nxt_dat = {29'h0000_0000, op_ff};
      ADR_ADDR:  nxt_dat = {11'h000, addr_ff};
      ADR_WDATA: nxt_dat = {16'h0000, wdata_ff};
      ADR_RDATA: nxt_dat = {16'h0000, res_ff};
      ADR_STAT:  nxt_dat = stat;
      default:   nxt_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff     <= S_IDLE;
      op_ff     <= OP_STATUS;
      addr_ff   <= ADDR_RST;
      wdata_ff  <= WDATA_RST;
      res_ff    <= 16'h0000;
      kind_ff   <= OP_READ;
      retry_ff  <= 4'h0;
      pbfail_ff <= 1'b0;
      ack_ff    <= 1'b0;
      dat_ff    <= 32'h0000_0000;
    end else begin
      st_ff     <= nxt_st;
      op_ff     <= nxt_op;
      addr_ff   <= nxt_addr;
      wdata_ff  <= nxt_wdata;
      res_ff    <= nxt_res;
      kind_ff   <= nxt_kind;
      retry_ff  <= nxt_retry;
      pbfail_ff <= nxt_pbfail;
      ack_ff    <= nxt_ack;
      dat_ff    <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  sr_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    kind_ff == OP_STATUS |-> res_ff[15:8] == 8'h00 && !res_ff[0])
    else $error("status reserved bits not masked");

  sr_busy_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    kind_ff == OP_STATUS && !res_ff[SR_READY] |-> res_ff[6:1] == 6'h00)
    else $error("status flags shown while busy");

  xsr_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    kind_ff == OP_XSTATUS |-> (res_ff & ~XSR_MASK) == 16'h0000)
    else $error("extended status reserved bits not masked");

  pcr_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    kind_ff == OP_PCR |-> (res_ff & ~PCR_MASK) == 16'h0000)
    else $error("configuration reserved bits not masked");

  pb_retry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff == S_EVAL && op_ff == OP_XSTATUS && !bus_rdata[XSR_PB_AVAIL]
    && retry_ff != RETRY_MAX |=> st_ff == S_CMD && req.data == CMD_PAGE_BUF)
    else $error("page buffer setup not reissued");

  seq_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff == S_EVAL && op_ff == OP_STATUS && bus_rdata[SR_READY] &&
    bus_rdata[SR_ERASE_ERR] && bus_rdata[SR_PROG_ERR]
    |=> stat[ST_SEQERR])
    else $error("sequence error decode wrong");

  four_part_a: assert property (@(posedge clk_i) disable iff (rst_i)
    kind_ff == OP_PCR && layout == 3'b111 |-> stat[ST_PCNT +: 2] == 2'h3)
    else $error("four partition decode wrong");

  three_part_a: assert property (@(posedge clk_i) disable iff (rst_i)
    kind_ff == OP_PCR && (layout == 3'b011 || layout == 3'b110 ||
    layout == 3'b101) |-> stat[ST_PCNT +: 2] == 2'h2)
    else $error("three partition decode wrong");

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !ack_ff |=> ack_ff ##1 !ack_ff)
    else $error("ack not a single cycle answer");

  status_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    st_ff == S_EVAL && op_ff == OP_STATUS && bus_rdata[SR_READY]);
  retry_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    st_ff == S_EVAL && op_ff == OP_XSTATUS && retry_ff != 4'h0);
  pcr_cv: cover property (@(posedge clk_i) disable iff (rst_i)
    st_ff == S_EVAL && op_ff == OP_PCR);

endmodule : fsp_host
`default_nettype wire

/* tb/fsp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model #(
  parameter bit TOP_PARAM = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [20:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        dq_oe_i,
  output logic      [15:0] dq_o,
  output logic             ready_busy_n_o,
  input  wire logic [7:0]  sr_i,
  input  wire logic        load_i,
  input  wire logic [2:0]  code_i,
  input  wire logic [3:0]  refuse_i,
  input  wire logic        junk_i,
  input  wire logic        wp_i
);
  logic [1:0]  lock_ff;
  logic        hist_ff;
  logic        wp_q_ff;
  logic        arm_ff;
  logic        abort_ff;
  logic [1:0]  mode_ff;
  logic [2:0]  pcr_ff;
  logic [3:0]  refuse_ff;
  logic        avail_ff;
  logic        we_q_ff;
  logic [15:0] cmd_ff;
  logic [15:0] wdat_ff;
  logic [20:0] wadr_ff;
  logic [15:0] last_ff;
  logic [15:0] fill;
  logic [15:0] rd;
  // ones in reserved bits only when a scenario makes the host mask them
  assign fill = junk_i ? 16'hFFFF : 16'h0000;
  assign ready_busy_n_o = sr_i[7];
  always_comb begin
    case (mode_ff)
      // per-partition flags are set up by the bench
      2'h1: rd = {fill[15:8],
                  sr_i[7:2],
                  sr_i[1] | abort_ff, fill[0]};
      2'h2: rd = {fill[15:8], avail_ff, fill[6:0]};
      2'h3: rd = (addr_i[2:0] == 3'h6) ? {fill[15:11], pcr_ff, fill[7:0]}
                                       : fill;
      default: rd = addr_i[15:0] ^ 16'hA5C3;
    endcase
  end
  // a released bus shows the inverse of its last value, not a kind constant
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last_ff;
  always_ff @(posedge clk_i) begin
    last_ff <= dq_o;
    we_q_ff <= we_n_i;
    if (!we_n_i && dq_oe_i) cmd_ff <= dq_i;
    if (rst_i) begin
      mode_ff   <= 2'h0;
      pcr_ff    <= TOP_PARAM ? 3'h4 : 3'h1;
      refuse_ff <= 4'h0;
      avail_ff  <= 1'b1;
      arm_ff    <= 1'b0;
      abort_ff  <= 1'b0;
    end else if (load_i) begin
      pcr_ff    <= code_i;
      refuse_ff <= refuse_i;
    end else if (!we_q_ff && we_n_i && !ce_n_i) begin
      wdat_ff <= cmd_ff;
      wadr_ff <= addr_i;
      arm_ff  <= (cmd_ff[7:0] == 8'h40);
      // program data after a setup write aborts on a locked block
      if (arm_ff && lock_ff[0]) abort_ff <= 1'b1;
      case (cmd_ff[7:0])
        8'h70: mode_ff <= 2'h1;
        8'hE8: begin
          mode_ff  <= 2'h2;
          avail_ff <= (refuse_ff == 4'h0);
          if (refuse_ff != 4'h0) refuse_ff <= refuse_ff - 4'h1;
        end
        8'h90: mode_ff <= 2'h3;
        default: mode_ff <= 2'h0;
      endcase
    end
  end
  // lock state {locked-down, locked} of the one block under test
  always_ff @(posedge clk_i) begin
    wp_q_ff <= wp_i;
    if (rst_i) begin
      lock_ff <= 2'b01;
      hist_ff <= 1'b0;
    end else if (wp_q_ff && !wp_i) begin
      // history tells the later rising edge where to return
      hist_ff <= (lock_ff == 2'b10);
      if (lock_ff[1]) lock_ff <= 2'b11;
    end else if (!wp_q_ff && wp_i && lock_ff == 2'b11 && hist_ff) begin
      lock_ff <= 2'b10;
    end
  end
endmodule : fsp_flash_model
`default_nettype wire

/* tb/tb_fsp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_fsp_host;
  import fsp_pkg::*;
  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
    string       nm;
  } fsp_note_s;
  localparam logic [1:0] PCNT [8] = '{2'h0, 2'h1, 2'h1, 2'h2,
                                      2'h1, 2'h2, 2'h2, 2'h3};
  localparam logic [3:0] PB_REF [4] = '{4'h0, 4'h3, 4'h8, 4'h9};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wp_r = 1'b1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [20:0] f_addr;
  logic        ce_n, oe_n, we_n, h_oe, rb_n;
  logic [15:0] h_dq, m_dq, dq_bus;
  logic [7:0]  sr_r = 8'h80;
  logic        load_r = 1'b0;
  logic        junk_r = 1'b0;
  logic [2:0]  code_r = 3'h0;
  logic [3:0]  ref_r = 4'h0;
  int          error_cnt = 0;
  int          n_checks = 0;
  fsp_note_s   q[$];
  fsp_note_s   cur;
  logic [31:0] d, er, es, sm;
  logic [20:0] a;
  logic [7:0]  s;
  assign dq_bus = h_oe ? h_dq : m_dq;
  always #12.5 clk_i = ~clk_i;
  fsp_host uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_addr_o(f_addr), .ce_n_o(ce_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .dq_o(h_dq), .dq_oe_o(h_oe),
    .dq_i(dq_bus), .ready_busy_n_i(rb_n));
  fsp_flash_model m (.clk_i(clk_i), .rst_i(rst_i), .addr_i(f_addr),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(h_dq),
    .dq_oe_i(h_oe), .dq_o(m_dq), .ready_busy_n_o(rb_n), .sr_i(sr_r),
    .load_i(load_r), .code_i(code_r), .refuse_i(ref_r), .junk_i(junk_r),
    .wp_i(wp_r));

  task stop_test;
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk_word(input string nm, input logic [31:0] exp,
                          input logic [31:0] msk, input logic [31:0] got);
    if (msk != 32'h0) begin
      n_checks++;
      if ((got & msk) !== (exp & msk)) begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h", nm, exp & msk, got & msk);
      end
    end
  endtask : chk_word

  // monitor: every read answer takes the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) begin
      cur = q.pop_front();
      chk_word(cur.nm, cur.exp, cur.msk, wb_dat_o);
    end
  end

  task automatic wb(input logic we, input logic [4:0] adr,
                    input logic [31:0] dat, output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_sel_i <= 4'h0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd_exp(input logic [4:0] adr, input logic [31:0] exp,
                        input logic [31:0] msk, input string nm);
    logic [31:0] rd;
    q.push_back('{exp, msk, nm});
    wb(1'b0, adr, 32'h0, rd);
  endtask : rd_exp

  // status polls carry an empty mask so the monitor stays in step
  task automatic wait_idle;
    logic [31:0] rd;
    rd = 32'h1;
    for (int i = 0; i < 400 && rd[ST_BUSY] !== 1'b0; i++) begin
      q.push_back('{32'h0, 32'h0, "poll"});
      wb(1'b0, ADR_STAT, 32'h0, rd);
    end
    if (rd[ST_BUSY] !== 1'b0) begin
      error_cnt++;
      $display("[FAIL] busy expected 0 seen %b", rd[ST_BUSY]);
    end
  endtask : wait_idle

  task automatic op_chk(input fsp_op_e op, input logic [31:0] exp_r,
                        input logic [31:0] exp_s, input logic [31:0] msk_s);
    logic [31:0] rd;
    wb(1'b1, ADR_CTRL, {29'h0, op}, rd);
    wait_idle();
    rd_exp(ADR_RDATA, exp_r, 32'hFFFF, "RDATA");
    rd_exp(ADR_STAT, exp_s, msk_s | 32'h1, "STAT");
  endtask : op_chk

  task automatic load(input logic [2:0] code, input logic [3:0] refuse);
    code_r <= code;
    ref_r  <= refuse;
    load_r <= 1'b1;
    @(posedge clk_i);
    load_r <= 1'b0;
  endtask : load

  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end

  initial begin
    d = $urandom(32'h38BB);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_exp(ADR_ADDR, {11'h0, ADDR_RST}, 32'hFFFFFFFF, "ADDR");
    rd_exp(ADR_WDATA, {16'h0, WDATA_RST}, 32'hFFFFFFFF, "WDATA");
    wb(1'b1, 5'h14, 32'hFFFFFFFF, d);
    rd_exp(5'h14, 32'h0, 32'hFFFFFFFF, "UNMAPPED");
    op_chk(OP_PCR, 32'h0100, 32'h0500, 32'h0700);
    junk_r <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      load(3'(c), 4'h0);
      es = (32'(PCNT[c]) << ST_PCNT) | (32'(c != 0) << ST_CONC);
      op_chk(OP_PCR, 32'(c) << PCR_LSB, es, 32'h0700);
    end
    for (int i = 0; i < 10; i++) begin
      s = (i == 0) ? 8'h00 : (i == 1) ? 8'hB0 : (i == 2) ? 8'hFE
                                                          : 8'($urandom);
      sr_r <= s;
      er = s[7] ? {24'h0, s & 8'hFE} : 32'h0;
      es = (32'(s[7]) << ST_READY) | (32'(s[7]) << ST_RB)
         | (32'(s[5] & s[4]) << ST_SEQERR);
      sm = (32'h1 << ST_READY) | (32'h1 << ST_RB) | (32'(s[7]) << ST_SEQERR);
      op_chk(OP_STATUS, er, es, sm);
    end
    for (int i = 0; i < 4; i++) begin
      load(3'h7, PB_REF[i]);
      er = (PB_REF[i] <= RETRY_MAX) ? 32'h0080 : 32'h0;
      es = (PB_REF[i] <= RETRY_MAX) ? 32'h1 << ST_PBAVAIL : 32'h1 << ST_PBFAIL;
      op_chk(OP_XSTATUS, er, es, 32'h18);
    end
    a = 21'($urandom);
    wb(1'b1, ADR_ADDR, {11'h0, a}, d);
    wb(1'b1, ADR_WDATA, 32'h00FF, d);
    wb(1'b1, ADR_CTRL, {29'h0, OP_WRITE}, d);
    wait_idle();
    chk_word("FLASH_WDATA", 32'h00FF, 32'hFFFF, {16'h0, m.wdat_ff});
    chk_word("FLASH_WADDR", {11'h0, a}, 32'h1FFFFF, {11'h0, m.wadr_ff});
    wb(1'b1, ADR_CTRL, {29'h0, OP_READ}, d);
    // address write while busy must be dropped
    wb(1'b1, ADR_ADDR, {11'h0, ~a}, d);
    wait_idle();
    rd_exp(ADR_RDATA, {16'h0, a[15:0] ^ 16'hA5C3}, 32'hFFFF, "RAW_READ");
    rd_exp(ADR_ADDR, {11'h0, a}, 32'h1FFFFF, "ADDR_BUSY");
    // an op code above the last one must not start anything
    wb(1'b1, ADR_CTRL, 32'h5, d);
    rd_exp(ADR_STAT, 32'h0, 32'h1, "BAD_OP");
    wp_r <= 1'b0;
    @(posedge clk_i);
    wp_r <= 1'b1;
    wb(1'b1, ADR_WDATA, 32'h0040, d);
    wb(1'b1, ADR_CTRL, {29'h0, OP_WRITE}, d);
    wait_idle();
    wb(1'b1, ADR_WDATA, 32'h1234, d);
    wb(1'b1, ADR_CTRL, {29'h0, OP_WRITE}, d);
    wait_idle();
    sr_r <= 8'h80;
    op_chk(OP_STATUS, 32'h0082, 32'h22, 32'h26);
    stop_test();
  end
endmodule : tb_fsp_host
`default_nettype wire
